/* rtl/decrement_jump_nonzero_dec_unit.sv */
// Decrement unit: subtracts one modulo 256 and flags a nonzero result.
// Assumes a purely combinational use by the sequencer.
`include "decrement_jump_nonzero_map.svh"
module dbne_dec_unit (
  dbne_if.alu dec_port
);
  always_comb begin
    dec_port.result  = dec_port.operand - `DBNE_DEC_ONE;
    dec_port.nonzero = (dec_port.result != `DBNE_ZERO);
  end
endmodule

/* rtl/decrement_jump_nonzero_exec.sv */
// Execution sequencer for the decrement_jump_nonzero instruction in both operand forms.
// Assumes the core presents the instruction bytes with a start strobe and answers reads in the same cycle.
`include "decrement_jump_nonzero_map.svh"
module dbne_exec (
  // Clock, reset and enable
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  // Instruction
  input  wire logic        I_START,
  input  wire logic [7:0]  I_OPCODE,
  input  wire logic [7:0]  I_BYTE2,
  input  wire logic [7:0]  I_BYTE3,
  input  wire logic [15:0] I_PC,
  input  wire logic [7:0]  I_PSW,
  // Operand access
  input  wire logic [7:0]  I_RD_DATA,
  output logic             O_RD_EN,
  output logic             O_RD_LATCH,
  output logic             O_WR_EN,
  output logic [7:0]       O_ADDR,
  output logic [7:0]       O_WR_DATA,
  // Program counter and status
  output logic             O_PC_LOAD,
  output logic [15:0]      O_PC,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic             O_TAKEN,
  output logic             O_PSW_WE
);

  // Decoded instruction.
  logic                  is_reg_form;
  logic                  is_dir_form;
  logic                  start_ok;
  logic [7:0]            reg_addr;

  // Control state.
  dbne_pkg::dbne_state_e state_reg;
  dbne_pkg::dbne_state_e state_next;

  // State decode.
  logic                  in_idle;
  logic                  in_read;
  logic                  in_write;
  logic                  in_done;

  // Operand state.
  dbne_pkg::dbne_byte_t  addr_reg;
  dbne_pkg::dbne_byte_t  addr_next;
  dbne_pkg::dbne_byte_t  data_reg;
  dbne_pkg::dbne_byte_t  data_next;
  logic                  nonzero_reg;
  logic                  nonzero_next;

  // Counter state.
  dbne_pkg::dbne_pc_t    pc_reg;
  dbne_pkg::dbne_pc_t    pc_next;
  dbne_pkg::dbne_byte_t  rel_reg;
  dbne_pkg::dbne_byte_t  rel_next;
  wire dbne_pkg::dbne_pc_t rel_ext;
  logic                  taken_reg;
  logic                  taken_next;

  // The decrement itself sits in its own unit behind the interface.
  dbne_if dec_bus ();

  dbne_dec_unit u_dec (
    .dec_port (dec_bus.alu)
  );

  // Instruction decode; a start with any other opcode is ignored.
  assign is_reg_form = (I_OPCODE[7:3] == `DBNE_OPC_REG_HI);
  assign is_dir_form = (I_OPCODE == `DBNE_OPC_DIR);
  assign start_ok    = I_START && (is_reg_form || is_dir_form);
  // Bank-select bits of the status word form address bits 4:3.
  assign reg_addr    = {3'h0, I_PSW[`DBNE_PSW_RS_LSB+1:`DBNE_PSW_RS_LSB], I_OPCODE[2:0]};

  // Sign extension of the displacement, one bit at a time above bit 7.
  assign rel_ext[7:0] = rel_reg;
  for (genvar gi = 8; gi < 16; gi = gi + 1) begin : g_sign
    assign rel_ext[gi] = rel_reg[7];
  end

  // The read data is decremented as it arrives, so the write value leaves a flip-flop.
  assign dec_bus.operand = I_RD_DATA;

  assign in_idle  = (state_reg == dbne_pkg::DBNE_IDLE);
  assign in_read  = (state_reg == dbne_pkg::DBNE_READ);
  assign in_write = (state_reg == dbne_pkg::DBNE_WRITE);
  assign in_done  = (state_reg == dbne_pkg::DBNE_DONE);

  // Four clocks per instruction: accept, read, write back, counter load.
  // A start that arrives while busy is ignored.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dbne_pkg::DBNE_IDLE: begin
        if (start_ok) begin
          state_next = dbne_pkg::DBNE_READ;
        end
      end
      dbne_pkg::DBNE_READ: begin
        state_next = dbne_pkg::DBNE_WRITE;
      end
      dbne_pkg::DBNE_WRITE: begin
        state_next = dbne_pkg::DBNE_DONE;
      end
      dbne_pkg::DBNE_DONE: begin
        state_next = dbne_pkg::DBNE_IDLE;
      end
      default: begin
        state_next = dbne_pkg::DBNE_IDLE;
      end
    endcase
  end

  // A low clock enable freezes every register, and so every strobe as well.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= dbne_pkg::DBNE_IDLE;
    end else if (I_CE) begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    addr_next    = addr_reg;
    data_next    = data_reg;
    nonzero_next = nonzero_reg;
    if (in_idle && start_ok) begin
      if (is_reg_form) begin
        addr_next = reg_addr;
      end else begin
        addr_next = I_BYTE2;
      end
    end
    if (in_read) begin
      data_next    = dec_bus.result;
      nonzero_next = dec_bus.nonzero;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_reg    <= `DBNE_RST_BYTE;
      data_reg    <= `DBNE_RST_BYTE;
      nonzero_reg <= 1'b0;
    end else if (I_CE) begin
      addr_reg    <= addr_next;
      data_reg    <= data_next;
      nonzero_reg <= nonzero_next;
    end
  end

  // The counter is first advanced past the whole instruction, so the displacement
  // is added to the address of the following instruction.
  always_comb begin
    pc_next    = pc_reg;
    rel_next   = rel_reg;
    taken_next = taken_reg;
    if (in_idle && start_ok) begin
      taken_next = 1'b0;
      if (is_reg_form) begin
        pc_next  = I_PC + `DBNE_LEN_REG;
        rel_next = I_BYTE2;
      end else begin
        pc_next  = I_PC + `DBNE_LEN_DIR;
        rel_next = I_BYTE3;
      end
    end
    // A zero operand has wrapped to all ones by now, so it branches.
    if (in_write) begin
      taken_next = nonzero_reg;
      if (nonzero_reg) begin
        pc_next = pc_reg + rel_ext;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pc_reg    <= `DBNE_RST_PC;
      rel_reg   <= `DBNE_RST_BYTE;
      taken_reg <= 1'b0;
    end else if (I_CE) begin
      pc_reg    <= pc_next;
      rel_reg   <= rel_next;
      taken_reg <= taken_next;
    end
  end

  // Strobes decode the state; the counter and the branch decision hold until the next start.
  always_comb begin
    O_RD_EN    = in_read;
    // Direct addresses in the special function space take port values from the output latch.
    O_RD_LATCH = in_read && (addr_reg >= `DBNE_DIRECT_SFR_MIN);
    O_WR_EN    = in_write;
    O_ADDR     = addr_reg;
    O_WR_DATA  = data_reg;
    O_PC_LOAD  = in_done;
    O_PC       = pc_reg;
    O_BUSY     = !in_idle;
    O_DONE     = in_done;
    O_TAKEN    = taken_reg;
    O_PSW_WE   = 1'b0;
  end

endmodule

/* rtl/decrement_jump_nonzero_if.sv */
// Interface carrying the operand decrement between the sequencer and the arithmetic unit.
// Assumes both ends share the core clock.
interface dbne_if;
  logic [7:0] operand;
  logic [7:0] result;
  logic       nonzero;
  modport seq (output operand, input result, input nonzero);
  modport alu (input operand, output result, output nonzero);
endinterface

/* rtl/decrement_jump_nonzero_map.svh */
// Offsets, field positions, reset values and counts for the decrement-and-branch execution logic.
// Assumes inclusion by bare name from the modules of this block.
`ifndef DBNE_MAP_SVH
`define DBNE_MAP_SVH
`define DBNE_OPC_REG_HI     5'h1B
`define DBNE_OPC_DIR        8'hD5
`define DBNE_LEN_REG        16'h0002
`define DBNE_LEN_DIR        16'h0003
`define DBNE_PSW_RS_LSB     3
`define DBNE_DIRECT_SFR_MIN 8'h80
`define DBNE_DEC_ONE        8'h01
`define DBNE_ZERO           8'h00
`define DBNE_RST_BYTE       8'h00
`define DBNE_RST_PC         16'h0000
`endif

/* rtl/decrement_jump_nonzero_pkg.sv */
// Types shared by the decrement-and-branch execution logic.
// Assumes it is compiled before the modules that use it.
package dbne_pkg;
  typedef enum logic [3:0] {
    DBNE_IDLE  = 4'h1,
    DBNE_READ  = 4'h2,
    DBNE_WRITE = 4'h4,
    DBNE_DONE  = 4'h8
  } dbne_state_e;
  typedef logic [7:0]  dbne_byte_t;
  typedef logic [15:0] dbne_pc_t;
endpackage

/* verif/decrement_jump_nonzero_chk.sv */
// Checker of the decrement-and-branch sequencer port timing.
// Assumes a bind from the bench top; attempts that meet a low clock enable are dropped.
module dbne_chk (
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_CE,
  input wire logic       I_START,
  input wire logic [7:0] I_OPCODE,
  input wire logic [7:0] I_RD_DATA,
  input wire logic       O_RD_EN,
  input wire logic       O_RD_LATCH,
  input wire logic       O_WR_EN,
  input wire logic [7:0] O_ADDR,
  input wire logic [7:0] O_WR_DATA,
  input wire logic       O_PC_LOAD,
  input wire logic       O_DONE,
  input wire logic       O_BUSY,
  input wire logic       O_TAKEN,
  input wire logic       O_PSW_WE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N || !I_CE);
  a_start_reads: assert property (I_START && !O_BUSY && (I_OPCODE[7:3] == 5'h1B || I_OPCODE == 8'hD5)
    |=> O_RD_EN) else $error("read strobe missing after start");
  a_wr_decrement: assert property (O_RD_EN |=> O_WR_EN && O_WR_DATA == $past(I_RD_DATA) - 8'h01)
    else $error("write value is not read value minus one");
  a_wr_same_addr: assert property (O_WR_EN |-> $stable(O_ADDR)) else $error("write address moved");
  a_load_after_wr: assert property (O_WR_EN |=> O_PC_LOAD && O_DONE) else $error("no counter load");
  a_flags_kept: assert property (!O_PSW_WE) else $error("status write seen");
  a_taken_nonzero: assert property (O_PC_LOAD |-> O_TAKEN == ($past(O_WR_DATA) != 8'h00))
    else $error("branch decision wrong");
  a_latch_sfr: assert property (O_RD_EN |-> O_RD_LATCH == O_ADDR[7]) else $error("latch select wrong");
  a_busy_span: assert property (O_RD_EN |-> O_BUSY [*3]) else $error("busy dropped early");
  a_refuse_idle: assert property (I_START && !O_BUSY && I_OPCODE[7:3] != 5'h1B && I_OPCODE != 8'hD5
    |=> !O_BUSY) else $error("busy after refused start");
  a_done_single: assert property (O_DONE |=> !O_BUSY) else $error("done held too long");
endmodule

/* verif/tb.sv */
// Self-checking bench of the decrement-and-branch sequencer.
// Assumes the design package and map header are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_start = 1'b0;
  logic [7:0] opc = 8'h00, b2 = 8'h00, b3 = 8'h00, psw = 8'h00, rdd = 8'h00;
  logic [15:0] pc = 16'h0000;
  wire logic rd, lat, wr, ld, done, busy, tkn, pswe;
  wire logic [7:0] adr, wd;
  wire logic [15:0] npc;
  int bad_count = 0, compares = 0;
  always #4 i_clk = ~i_clk;
  dbne_exec dbne_exec_inst (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_CE(i_ce), .I_START(i_start),
    .I_OPCODE(opc), .I_BYTE2(b2), .I_BYTE3(b3), .I_PC(pc), .I_PSW(psw), .I_RD_DATA(rdd),
    .O_RD_EN(rd), .O_RD_LATCH(lat), .O_WR_EN(wr), .O_ADDR(adr), .O_WR_DATA(wd),
    .O_PC_LOAD(ld), .O_PC(npc), .O_BUSY(busy), .O_DONE(done), .O_TAKEN(tkn), .O_PSW_WE(pswe));
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("Mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task run(input logic [7:0] o, a, d, s, v, ea, input logic el, input logic [15:0] p, ep, input logic et);
    @(posedge i_clk) #1;
    {i_start, opc, b2, b3, psw, rdd, pc} = {1'b1, o, a, d, s, v, p};
    @(posedge i_clk) #1 i_start = 1'b0;
    chk({rd, lat, adr}, {1'b1, el, ea});
    @(posedge i_clk) #1 chk({wr, wd}, {1'b1, v - 8'h01});
    @(posedge i_clk) #1 chk(npc, ep);
    chk({ld, done, tkn, pswe}, {2'b11, et, 1'b0});
  endtask
  task t_reg_zero; run(8'hDB, 8'h10, 8'h00, 8'h10, 8'h01, 8'h13, 1'b0, 16'h1000, 16'h1002, 1'b0); endtask
  task t_reg_wrap; run(8'hD8, 8'hFE, 8'h00, 8'h18, 8'h00, 8'h18, 1'b0, 16'h2000, 16'h2000, 1'b1); endtask
  task t_dir_port; run(8'hD5, 8'h90, 8'h05, 8'h00, 8'h70, 8'h90, 1'b1, 16'h0100, 16'h0108, 1'b1); endtask
  task t_dir_ram; run(8'hD5, 8'h40, 8'h80, 8'h08, 8'h15, 8'h40, 1'b0, 16'h0200, 16'h0183, 1'b1); endtask
  task t_freeze_busy;
    @(posedge i_clk) #1;
    {i_start, opc, b2, b3, psw, rdd, pc} = {1'b1, 8'hD9, 8'h03, 8'h00, 8'h00, 8'h05, 16'h3000};
    @(posedge i_clk) #1 {i_ce, opc, b2} = {1'b0, 8'hD5, 8'h77};
    chk({rd, adr}, {1'b1, 8'h01});
    @(posedge i_clk) #1 i_ce = 1'b1;
    chk({rd, wr, adr}, {2'b10, 8'h01});
    @(posedge i_clk) #1 i_start = 1'b0;
    chk({wr, wd, adr}, {1'b1, 8'h04, 8'h01});
    @(posedge i_clk) #1 chk({ld, tkn, npc}, {2'b11, 16'h3005});
  endtask
  task t_reset_mid;
    @(posedge i_clk) #1 {i_start, opc, b2, psw, rdd} = {1'b1, 8'hDF, 8'h04, 8'h08, 8'h09};
    @(posedge i_clk) #1 chk({rd, adr}, {1'b1, 8'h0F});
    {i_start, i_rst_n} = 2'b00;
    #1 chk({busy, rd, wr, ld, tkn, adr, wd}, 21'h0);
    chk(npc, 16'h0000);
    @(posedge i_clk) #1 i_rst_n = 1'b1;
    @(posedge i_clk) #1 chk({busy, rd}, 2'b00);
  endtask
  task t_refuse;
    @(posedge i_clk) #1 {i_start, opc} = {1'b1, 8'hC8};
    @(posedge i_clk) #1 i_start = 1'b0;
    chk({busy, rd}, 2'b00);
  endtask
  initial begin
    #20000 bad_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    t_reg_zero();
    t_reg_wrap();
    t_dir_port();
    t_dir_ram();
    t_freeze_busy();
    t_reset_mid();
    t_refuse();
    give_verdict();
  end
endmodule
bind dbne_exec dbne_chk dbne_chk_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_START(I_START),
  .I_OPCODE(I_OPCODE),
  .I_RD_DATA(I_RD_DATA), .O_RD_EN(O_RD_EN), .O_RD_LATCH(O_RD_LATCH), .O_WR_EN(O_WR_EN), .O_ADDR(O_ADDR),
  .O_WR_DATA(O_WR_DATA), .O_PC_LOAD(O_PC_LOAD), .O_DONE(O_DONE), .O_BUSY(O_BUSY), .O_TAKEN(O_TAKEN),
  .O_PSW_WE(O_PSW_WE));
